// File: hdl/mpb_top.sv
// Eight-channel pulse-width generator with continuous and burst modes.
// Assumes one 100 MHz clock and a simple strobe register port.
`default_nettype none

////////////////////////////////////////////////////////////////////////
// What this block does
// - Eight independent channels, each with frequency, duty, count, run, status.
// - Duty is high time over full period, 0.1% to 99.9%.
// - Duty given in thousandths, 1 to 999; software keeps it in range.
// - Frequency is whole hertz 1 to 500000; output period is 100 MHz over it, rounded down to whole clocks.
// - Count of minus one runs pulses continuously while running.
// - Count 1 to 65535 emits exactly that many pulses then stops.
// - Run high starts a channel, run low stops it.
// - Status bit is high while the channel is producing pulses.
module mpb_top #(
	parameter int unsigned NCH = mpb_pkg::NUM_CH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Channel outputs
	output logic [NCH-1:0] pulse_out
);
	localparam int unsigned PW = mpb_pkg::PER_W;
	// Wide enough for the longest period times the largest duty
	localparam int unsigned DW = 40;

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [NCH-1:0][mpb_pkg::FREQ_W-1:0] freq;
		logic [NCH-1:0][mpb_pkg::DUTY_W-1:0] duty;
		logic [NCH-1:0][mpb_pkg::CNT_W-1:0] count;
		logic [NCH-1:0] run;
		logic [NCH-1:0][PW-1:0] period;
		logic [NCH-1:0][PW-1:0] high;
		logic [NCH-1:0] dirty;
		logic [2:0] sel;
		logic phase;
		logic go;
		logic [31:0] rdata;
	} mpb_top_s;
	mpb_top_s r;
	mpb_top_s next_r;

	logic div_busy;
	logic div_done;
	logic [DW-1:0] div_q;
	logic [DW-1:0] div_num;
	logic [DW-1:0] div_den;
	logic [NCH-1:0] ch_out;
	logic [NCH-1:0] ch_active;
	logic [2:0] wch;
	logic [2:0] wfield;
	logic wr_sel;

	assign wch = reg_addr[2:0];
	assign wfield = reg_addr[5:3];
	assign wr_sel = reg_wr && wch == r.sel &&
		(wfield == mpb_pkg::ADDR_FREQ || wfield == mpb_pkg::ADDR_DUTY);

	////////////////////////////////////////////////////////////////////
	// One shared divider converts hertz to period, then duty to high
	// time; saves seven dividers at the cost of a short update lag.
	always_comb begin
		div_num = '0;
		div_den = DW'(1);
		if (!r.phase) begin
			div_num = DW'(mpb_pkg::CLK_HZ);
			div_den = (r.freq[r.sel] == '0) ? DW'(1) : DW'(r.freq[r.sel]);
		end else begin
			div_num = DW'(r.period[r.sel]) * DW'(r.duty[r.sel]);
			div_den = DW'(mpb_pkg::DUTY_SCALE);
		end
	end

	mpb_divider #(
		.W(DW)
	) u_div (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(r.go),
		.num(div_num),
		.den(div_den),
		.busy(div_busy),
		.done(div_done),
		.quot(div_q)
	);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		next_r.go = 1'b0;
		if (reg_wr) begin
			case (wfield)
				mpb_pkg::ADDR_FREQ: begin
					next_r.freq[wch] = reg_wdata[mpb_pkg::FREQ_W-1:0];
					next_r.dirty[wch] = 1'b1;
				end
				mpb_pkg::ADDR_DUTY: begin
					next_r.duty[wch] = reg_wdata[mpb_pkg::DUTY_W-1:0];
					next_r.dirty[wch] = 1'b1;
				end
				mpb_pkg::ADDR_CNT: begin
					next_r.count[wch] = reg_wdata[mpb_pkg::CNT_W-1:0];
				end
				mpb_pkg::ADDR_RUN: begin
					next_r.run = reg_wdata[NCH-1:0];
				end
				default: begin
				end
			endcase
		end
		if (!div_busy && !r.go && !div_done) begin
			if (r.dirty[r.sel] && !r.phase) begin
				next_r.go = 1'b1;
				// Clear on start; a write during the divide sets it again
				if (!wr_sel) begin
					next_r.dirty[r.sel] = 1'b0;
				end
			end else if (!r.dirty[r.sel]) begin
				next_r.sel = r.sel + 3'h1;
			end
		end
		if (div_done) begin
			if (!r.phase) begin
				next_r.period[r.sel] = div_q[PW-1:0];
				next_r.phase = 1'b1;
				next_r.go = 1'b1;
			end else begin
				next_r.high[r.sel] = (div_q[PW-1:0] == '0) ?
					PW'(1) : div_q[PW-1:0];
				next_r.phase = 1'b0;
			end
		end
		next_r.rdata = 32'h0;
		if (reg_rd) begin
			case (wfield)
				mpb_pkg::ADDR_FREQ: next_r.rdata = 32'(r.freq[wch]);
				mpb_pkg::ADDR_DUTY: next_r.rdata = 32'(r.duty[wch]);
				mpb_pkg::ADDR_CNT: next_r.rdata = 32'(r.count[wch]);
				mpb_pkg::ADDR_RUN: next_r.rdata = 32'(r.run);
				mpb_pkg::ADDR_STATUS: next_r.rdata = 32'(ch_active);
				default: next_r.rdata = 32'h0;
			endcase
		end
		if (!rst_n) begin
			next_r = '0;
			for (int i = 0; i < NCH; i++) begin
				next_r.freq[i] = mpb_pkg::FREQ_RST;
				next_r.duty[i] = mpb_pkg::DUTY_RST;
				next_r.count[i] = mpb_pkg::CNT_RST;
				next_r.period[i] = PW'(mpb_pkg::CLK_HZ / 100);
				next_r.high[i] = PW'(mpb_pkg::CLK_HZ / 200);
			end
		end
	end

	always_ff @(posedge mclk) begin
		r <= next_r;
	end

	////////////////////////////////////////////////////////////////////
	// eight channels
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			mpb_channel #(
				.PW(PW),
				.CW(mpb_pkg::CNT_W)
			) u_ch (
				.mclk(mclk),
				.rst_n(rst_n),
				.run(r.run[g]),
				.period(r.period[g]),
				.high(r.high[g]),
				.count(r.count[g]),
				.pulse_out(ch_out[g]),
				.active(ch_active[g])
			);
		end
	endgenerate

	assign pulse_out = ch_out;
	assign reg_rdata = r.rdata;
endmodule : mpb_top
`default_nettype wire

// File: hdl/mpb_pkg.sv
// Package for the eight-channel pulse-width burst generator.
// Assumes a single 100 MHz clock with synchronous active-low reset.
`default_nettype none
package mpb_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned NUM_CH = 8;
	localparam int unsigned FREQ_W = 19;
	localparam int unsigned DUTY_W = 10;
	localparam int unsigned CNT_W = 17;
	localparam int unsigned PER_W = 27;
	localparam int unsigned FREQ_MIN = 1;
	localparam int unsigned FREQ_MAX = 500_000;
	localparam int unsigned DUTY_MIN = 1;
	localparam int unsigned DUTY_MAX = 999;
	localparam int unsigned DUTY_SCALE = 1000;
	localparam int unsigned BURST_MAX = 65535;
	localparam logic [16:0] CNT_CONT = 17'h1ffff;
	localparam logic [2:0] ADDR_FREQ = 3'h0;
	localparam logic [2:0] ADDR_DUTY = 3'h1;
	localparam logic [2:0] ADDR_CNT = 3'h2;
	localparam logic [2:0] ADDR_RUN = 3'h3;
	localparam logic [2:0] ADDR_STATUS = 3'h4;
	localparam logic [18:0] FREQ_RST = 19'h00064;
	localparam logic [9:0] DUTY_RST = 10'h1f4;
	localparam logic [16:0] CNT_RST = 17'h1ffff;
	typedef enum logic [1:0] {
		MPB_IDLE = 2'b00,
		MPB_RUN = 2'b01,
		MPB_DONE = 2'b10
	} mpb_state_e;
endpackage : mpb_pkg
`default_nettype wire

// File: hdl/mpb_divider.sv
// Sequential restoring divider: quotient = num / den, unsigned.
// Assumes den is nonzero and inputs steady from start to done.
`default_nettype none
module mpb_divider #(
	parameter int unsigned W = 32
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Request
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	// Answer
	output logic busy,
	output logic done,
	output logic [W-1:0] quot
);
	typedef struct packed {
		logic busy;
		logic done;
		logic [W-1:0] rem;
		logic [W-1:0] q;
		logic [$clog2(W+1)-1:0] n;
	} mpb_div_s;
	mpb_div_s r;
	mpb_div_s next_r;
	always_comb begin
		logic [W:0] trial;
		trial = '0;
		next_r = r;
		next_r.done = 1'b0;
		if (start && !r.busy) begin
			next_r.busy = 1'b1;
			next_r.rem = '0;
			next_r.q = num;
			next_r.n = ($clog2(W+1))'(W);
		end else if (r.busy) begin
			trial = {r.rem, r.q[W-1]} - {1'b0, den};
			if (!trial[W]) begin
				next_r.rem = trial[W-1:0];
				next_r.q = {r.q[W-2:0], 1'b1};
			end else begin
				next_r.rem = {r.rem[W-2:0], r.q[W-1]};
				next_r.q = {r.q[W-2:0], 1'b0};
			end
			next_r.n = r.n - 1'b1;
			if (r.n == 1) begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
		end
		if (!rst_n) begin
			next_r = '0;
		end
	end
	always_ff @(posedge mclk) begin
		r <= next_r;
	end
	assign busy = r.busy;
	assign done = r.done;
	assign quot = r.q;
endmodule : mpb_divider
`default_nettype wire

// File: hdl/mpb_channel.sv
// One output channel: counts period and high time, tracks burst pulses.
// Assumes period and high counts may change at any cycle; they are read live.
`default_nettype none
module mpb_channel #(
	parameter int unsigned PW = mpb_pkg::PER_W,
	parameter int unsigned CW = mpb_pkg::CNT_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	input wire logic [PW-1:0] period,
	input wire logic [PW-1:0] high,
	input wire logic [CW-1:0] count,
	// Outputs
	output logic pulse_out,
	output logic active
);
	typedef struct packed {
		mpb_pkg::mpb_state_e st;
		logic [PW-1:0] tick;
		logic [CW-1:0] left;
		logic out;
	} mpb_ch_s;
	mpb_ch_s r;
	mpb_ch_s next_r;
	always_comb begin
		next_r = r;
		case (r.st)
			mpb_pkg::MPB_IDLE: begin
				next_r.out = 1'b0;
				if (run) begin
					next_r.st = mpb_pkg::MPB_RUN;
					next_r.tick = '0;
					next_r.left = count;
					next_r.out = 1'b1;
				end
			end
			mpb_pkg::MPB_RUN: begin
				if (!run) begin
					next_r.st = mpb_pkg::MPB_IDLE;
					next_r.out = 1'b0;
				end else if (r.tick >= period - 1'b1) begin
					// A shorter period stored mid-count wraps at once
					next_r.tick = '0;
					if (r.left != mpb_pkg::CNT_CONT && r.left <= 1) begin
						next_r.st = mpb_pkg::MPB_DONE;
						next_r.out = 1'b0;
					end else begin
						next_r.out = 1'b1;
						if (r.left != mpb_pkg::CNT_CONT) begin
							next_r.left = r.left - 1'b1;
						end
					end
				end else begin
					next_r.tick = r.tick + 1'b1;
					next_r.out = (r.tick + 1'b1) < high;
				end
			end
			mpb_pkg::MPB_DONE: begin
				next_r.out = 1'b0;
				if (!run) begin
					next_r.st = mpb_pkg::MPB_IDLE;
				end
			end
			default: begin
				next_r.st = mpb_pkg::MPB_IDLE;
			end
		endcase
		if (!rst_n) begin
			next_r = '0;
		end
	end
	always_ff @(posedge mclk) begin
		r <= next_r;
	end
	assign pulse_out = r.out;
	assign active = (r.st == mpb_pkg::MPB_RUN);
endmodule : mpb_channel
`default_nettype wire

// File: bench/mpb_load.sv
// Pulse load on one channel: counts rising edges, measures high and period.
// Assumes the pin is a registered output sampled on mclk.
`default_nettype none
module mpb_load (
	// Clock and control
	input wire logic mclk,
	input wire logic clr,
	// Load input
	input wire logic pin,
	// Measurements
	output int edges,
	output int hi,
	output int per
);
	logic prev = 1'b0;
	int hc = 0;
	int pc = 0;
	// A plain input only listens, so no level is ever driven back
	always @(posedge mclk) begin
		if (clr) begin
			edges <= 0;
			hc <= 0;
			pc <= 0;
		end else begin
			if (pin && !prev) begin
				edges <= edges + 1;
				per <= pc;
				pc <= 1;
			end else begin
				pc <= pc + 1;
			end
			if (pin) begin
				hc <= hc + 1;
			end else if (prev) begin
				hi <= hc;
				hc <= 0;
			end
		end
		prev <= pin;
	end
endmodule : mpb_load
`default_nettype wire

// File: bench/mpb_top_props.sv
// Port checks for the pulse generator.
// Assumes register map field in reg_addr[5:3], channel in [2:0].
`default_nettype none
module mpb_top_props #(
	parameter int unsigned NCH = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [5:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Outputs
	input wire logic [NCH-1:0] pulse_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic run_wr;
	logic st_rd;
	assign run_wr = reg_wr && reg_addr[5:3] == 3'h3;
	assign st_rd = reg_rd && reg_addr[5:3] == 3'h4;
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (reg_rd && reg_addr[5:3] > 3'h4 |=>
		reg_rdata == 32'h0) else $error("unmapped read not zero");
	a_status_upper: assert property (st_rd |=> reg_rdata[31:NCH] == '0)
		else $error("status upper bits set");
	a_status_out: assert property (st_rd |=>
		(reg_rdata[NCH-1:0] & $past(pulse_out)) == $past(pulse_out))
		else $error("output high with status clear");
	a_stop_low: assert property (run_wr && reg_wdata[7:0] == 8'h0 |->
		##2 pulse_out == '0) else $error("output not low after stop");
	a_run_start: assert property (run_wr && reg_wdata[7:0] == 8'h0 ##1
		run_wr && reg_wdata[7:0] == 8'hff |-> ##2 pulse_out == '1)
		else $error("outputs not high after start");
	a_reset_low: assert property ($rose(rst_n) |-> pulse_out == '0)
		else $error("output high after reset");
	a_freq_width: assert property (reg_rd && reg_addr[5:3] == 3'h0 |=>
		reg_rdata[31:19] == '0) else $error("frequency read too wide");
	c_restart: cover property (run_wr ##1 run_wr);
	c_status_on: cover property (st_rd ##1 reg_rdata[0]);
	c_pulse_end: cover property ($fell(pulse_out[0]));
endmodule : mpb_top_props
bind mpb_top mpb_top_props #(.NCH(NCH)) i_props (.mclk(mclk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pulse_out(pulse_out));
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the pulse generator, load model on channel 0.
// Assumes a 100 MHz clock and the register map of the design notes.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic clr = 1'b1;
	logic [5:0] reg_addr = 6'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [7:0] pulse_out;
	int edges, hi, per;
	int miscompares = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #5 mclk = ~mclk;
	mpb_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pulse_out(pulse_out));
	mpb_load i_load (.mclk(mclk), .clr(clr), .pin(pulse_out[0]),
		.edges(edges), .hi(hi), .per(per));
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [5:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task rd(input logic [5:0] a, input logic [31:0] e, input string n);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata);
		@(posedge mclk);
	endtask : rd
	// Stop then start back to back, so a finished burst rearms
	task restart(input logic [7:0] m);
		clr <= 1'b1;
		reg_addr <= 6'h18;
		reg_wdata <= 32'h0;
		reg_wr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		reg_wdata <= {24'h0, m};
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : restart
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task t_regs;
		rd(6'h00, 32'd100, "freq0");
		rd(6'h0f, 32'd500, "duty7");
		rd(6'h10, 32'h1ffff, "count0");
		rd(6'h18, 32'h0, "run");
		wr(6'h20, 32'hff);
		rd(6'h20, 32'h0, "status");
		rd(6'h38, 32'h0, "unmapped");
		wr(6'h00, 32'd500000);
		rd(6'h00, 32'd500000, "freq_max");
		$display("test regs done");
	endtask : t_regs
	task automatic t_cont;
		int d[3] = '{250, 1, 999};
		int h[3] = '{50, 1, 199};
		for (int i = 0; i < 3; i++) begin
			wr(6'h08, d[i]);
			repeat (1000) @(posedge mclk);
			restart(8'h01);
			repeat (700) @(posedge mclk);
			chk("period", 32'd200, per);
			chk("high", h[i], hi);
			rd(6'h20, 32'h1, "status_run");
		end
		wr(6'h18, 32'h0);
		$display("test continuous done");
	endtask : t_cont
	task t_burst;
		wr(6'h10, 32'd3);
		restart(8'h01);
		repeat (1000) @(posedge mclk);
		chk("burst_edges", 32'd3, edges);
		chk("burst_low", 32'h0, pulse_out);
		rd(6'h20, 32'h0, "status_done");
		wr(6'h18, 32'h1);
		repeat (700) @(posedge mclk);
		chk("no_rearm", 32'd3, edges);
		wr(6'h10, 32'hffffffff);
		restart(8'hff);
		repeat (5) @(posedge mclk);
		chk("all_high", 32'hff, pulse_out);
		rd(6'h20, 32'hff, "status_all");
		repeat (900) @(posedge mclk);
		chk("cont_edges", 32'd5, edges);
		wr(6'h18, 32'h0);
		#1 chk("stopped", 32'h0, pulse_out);
		rd(6'h20, 32'h0, "status_stop");
		$display("test burst done");
	endtask : t_burst
	// Reset in mid-run must silence every output and restore defaults
	task t_reset;
		restart(8'hff);
		repeat (3) @(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk("reset_low", 32'h0, pulse_out);
		rd(6'h00, 32'd100, "freq_rst");
		rd(6'h18, 32'h0, "run_rst");
		rd(6'h20, 32'h0, "status_rst");
		$display("test reset done");
	endtask : t_reset
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			end_sim;
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		clr <= 1'b0;
		t_regs;
		t_cont;
		t_burst;
		t_reset;
		end_sim;
	end
endmodule : testbench
`default_nettype wire
